/* File: hw/laser_seq_pkg.sv */
// laser_seq_pkg: shared constants for the laser-source module sequencer.
// assumes a 200 MHz system clock and an axi4-lite management bus.
`default_nettype none

package laser_seq_pkg;

  // module state machine encoding
  typedef enum logic [2:0] {
    ST_RESETTING = 3'h0,
    ST_RESET     = 3'h1,
    ST_MGMT_INIT = 3'h2,
    ST_LOW_POWER = 3'h3,
    ST_READY     = 3'h4
  } mod_state_e;

  // clock and sequencing times
  localparam int unsigned CLK_PERIOD_NS = 5;
  localparam int unsigned RESETTING_TIME_NS = 100;
  localparam int unsigned MGMT_INIT_TIME_NS = 500;
  // least times round up to whole cycles
  localparam int unsigned RESETTING_CYCLES =
    (RESETTING_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned MGMT_INIT_CYCLES =
    (MGMT_INIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CNT_W = 8;

  // register byte offsets
  localparam logic [3:0] OFS_CONTROL = 4'h0;
  localparam logic [3:0] OFS_STATUS = 4'h4;
  localparam logic [3:0] OFS_POWER_CLASS = 4'h8;

  // control fields
  localparam int unsigned CTL_RESET_FLAG = 0;
  localparam int unsigned CTL_LASER_REQ = 1;
  localparam int unsigned CTL_COOLER_REQ = 2;
  localparam logic [2:0] CTL_RESET_VAL = 3'h1;

  // status fields
  localparam int unsigned STS_STATE_LSB = 0;
  localparam int unsigned STS_LASER = 4;
  localparam int unsigned STS_COOLER = 5;
  localparam int unsigned STS_LP_REQ = 6;

  // power class encoding
  localparam logic [3:0] PCLASS_MIN = 4'h1;
  localparam logic [3:0] PCLASS_MAX = 4'hA;
  localparam logic [3:0] PCLASS_LOW_POWER = 4'h1;
  localparam logic [3:0] PCLASS_DEFAULT = 4'h7;

  // axi response codes
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

`default_nettype wire

/* File: hw/laser_module_state_sequencer.sv */
// laser_module_state_sequencer: module-side state sequencing of a
// pluggable laser source, with an axi4-lite register slave.
// assumes host pins arrive asynchronously; bus is on CLOCK_I.
//
// Behaviour
// - after insertion every laser is held off until explicitly enabled.
// - after insertion the module sits in resetting, then moves to reset.
// - in reset it waits for the reset flag to be false, then initialises.
// - when management init ends the module enters the low power state.
// - in the low power state all laser power is kept off.
// - lasers turn on only in the ready state on an explicit host request.
// - low power keeps only the controller powered so it can still talk.
// - coolers may be enabled before the lasers are.
// - the module reports its power consumption as a power class.
// - the class is coded 1 to 10, class 1 meaning low power mode.
`default_nettype none

module laser_module_state_sequencer #(
  parameter logic [3:0] POWER_CLASS = laser_seq_pkg::PCLASS_DEFAULT
) (
  input wire logic CLOCK_I, // system clock, 200 MHz
  input wire logic RESET_I, // synchronous reset, active high
  input wire logic CE_I, // clock enable, freezes all state when low
  input wire logic MODULE_SELECT_N_I, // host select pin, active low
  input wire logic MODULE_RESET_N_I, // host reset pin, active low
  input wire logic LOW_POWER_REQUEST_I, // host low power pin
  output logic MODULE_PRESENT_N_O, // presence, grounded by module
  output logic MCU_POWER_EN_O, // controller supply enable
  output logic LASER_EN_O, // laser supply enable
  output logic COOLER_EN_O, // thermo cooler supply enable
  input wire logic [3:0] S_AXI_AWADDR, // write address
  input wire logic S_AXI_AWVALID, // write address valid
  output logic S_AXI_AWREADY, // write address ready
  input wire logic [31:0] S_AXI_WDATA, // write data
  input wire logic [3:0] S_AXI_WSTRB, // write byte strobes
  input wire logic S_AXI_WVALID, // write data valid
  output logic S_AXI_WREADY, // write data ready
  output logic [1:0] S_AXI_BRESP, // write response
  output logic S_AXI_BVALID, // write response valid
  input wire logic S_AXI_BREADY, // write response ready
  input wire logic [3:0] S_AXI_ARADDR, // read address
  input wire logic S_AXI_ARVALID, // read address valid
  output logic S_AXI_ARREADY, // read address ready
  output logic [31:0] S_AXI_RDATA, // read data
  output logic [1:0] S_AXI_RRESP, // read response
  output logic S_AXI_RVALID, // read data valid
  input wire logic S_AXI_RREADY // read data ready
);

  ////////////////////////////////////////////////////////////////////////
  // pin synchronisers

  logic [1:0] sel_n_sync_q;
  logic [1:0] rst_n_sync_q;
  logic [1:0] lp_sync_q;
  logic sel_s;
  logic mod_rst_s;
  logic lp_s;

  always_ff @(posedge CLOCK_I) begin
    if (RESET_I) begin
      sel_n_sync_q <= 2'h3;
      rst_n_sync_q <= 2'h0;
      lp_sync_q <= 2'h3;
    end else if (CE_I) begin
      sel_n_sync_q <= {sel_n_sync_q[0], MODULE_SELECT_N_I};
      rst_n_sync_q <= {rst_n_sync_q[0], MODULE_RESET_N_I};
      lp_sync_q <= {lp_sync_q[0], LOW_POWER_REQUEST_I};
    end
  end

  assign sel_s = ~sel_n_sync_q[1];
  assign mod_rst_s = ~rst_n_sync_q[1];
  assign lp_s = lp_sync_q[1];

  ////////////////////////////////////////////////////////////////////////
  // register bus: write and read channels

  logic aw_held_q;
  logic w_held_q;
  logic [3:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic rvalid_q;
  logic [1:0] rresp_q;
  logic [31:0] rdata_q;
  logic wr_go;
  logic ctl_wr;
  logic [2:0] ctl_q;
  logic [2:0] ctl_d;

  function automatic logic mapped(input logic [3:0] a);
    mapped = (a == laser_seq_pkg::OFS_CONTROL) ||
             (a == laser_seq_pkg::OFS_STATUS) ||
             (a == laser_seq_pkg::OFS_POWER_CLASS);
  endfunction

  assign S_AXI_AWREADY = CE_I & ~aw_held_q & ~bvalid_q;
  assign S_AXI_WREADY = CE_I & ~w_held_q & ~bvalid_q;
  assign S_AXI_ARREADY = CE_I & ~rvalid_q;
  assign S_AXI_BVALID = bvalid_q;
  assign S_AXI_BRESP = bresp_q;
  assign S_AXI_RVALID = rvalid_q;
  assign S_AXI_RRESP = rresp_q;
  assign S_AXI_RDATA = rdata_q;
  assign wr_go = aw_held_q & w_held_q & ~bvalid_q;
  // a deselected module ignores control writes but still answers
  assign ctl_wr = wr_go & sel_s & w_strb_q[0] &
                  (aw_addr_q == laser_seq_pkg::OFS_CONTROL);

  always_ff @(posedge CLOCK_I) begin
    if (RESET_I) begin
      aw_held_q <= 1'b0;
      aw_addr_q <= 4'h0;
    end else if (CE_I) begin
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
        aw_held_q <= 1'b1;
        aw_addr_q <= S_AXI_AWADDR;
      end else if (wr_go) begin
        aw_held_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge CLOCK_I) begin
    if (RESET_I) begin
      w_held_q <= 1'b0;
      w_data_q <= 32'h0;
      w_strb_q <= 4'h0;
    end else if (CE_I) begin
      if (S_AXI_WVALID && S_AXI_WREADY) begin
        w_held_q <= 1'b1;
        w_data_q <= S_AXI_WDATA;
        w_strb_q <= S_AXI_WSTRB;
      end else if (wr_go) begin
        w_held_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge CLOCK_I) begin
    if (RESET_I) begin
      bvalid_q <= 1'b0;
      bresp_q <= laser_seq_pkg::RESP_OKAY;
    end else if (CE_I) begin
      if (wr_go) begin
        bvalid_q <= 1'b1;
        bresp_q <= mapped(aw_addr_q) ? laser_seq_pkg::RESP_OKAY :
                   laser_seq_pkg::RESP_SLVERR;
      end else if (S_AXI_BREADY) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // module state machine

  laser_seq_pkg::mod_state_e state_q;
  laser_seq_pkg::mod_state_e state_d;
  logic [laser_seq_pkg::CNT_W-1:0] cnt_q;
  logic cnt_done;
  logic laser_q;
  logic cooler_q;

  assign cnt_done = (state_q == laser_seq_pkg::ST_RESETTING) ?
    (cnt_q == laser_seq_pkg::CNT_W'(laser_seq_pkg::RESETTING_CYCLES - 1)) :
    (cnt_q == laser_seq_pkg::CNT_W'(laser_seq_pkg::MGMT_INIT_CYCLES - 1));

  // software restarts the sequence by setting the reset flag again
  always_comb begin
    state_d = state_q;
    if (mod_rst_s) begin
      state_d = laser_seq_pkg::ST_RESETTING;
    end else begin
      unique case (state_q)
        laser_seq_pkg::ST_RESETTING: begin
          if (cnt_done) begin
            state_d = laser_seq_pkg::ST_RESET;
          end
        end
        laser_seq_pkg::ST_RESET: begin
          if (!ctl_q[laser_seq_pkg::CTL_RESET_FLAG]) begin
            state_d = laser_seq_pkg::ST_MGMT_INIT;
          end
        end
        laser_seq_pkg::ST_MGMT_INIT: begin
          if (cnt_done) begin
            state_d = laser_seq_pkg::ST_LOW_POWER;
          end
        end
        laser_seq_pkg::ST_LOW_POWER: begin
          if (ctl_q[laser_seq_pkg::CTL_RESET_FLAG]) begin
            state_d = laser_seq_pkg::ST_RESETTING;
          end else if (!lp_s) begin
            state_d = laser_seq_pkg::ST_READY;
          end
        end
        laser_seq_pkg::ST_READY: begin
          if (ctl_q[laser_seq_pkg::CTL_RESET_FLAG]) begin
            state_d = laser_seq_pkg::ST_RESETTING;
          end else if (lp_s) begin
            state_d = laser_seq_pkg::ST_LOW_POWER;
          end
        end
        default: state_d = laser_seq_pkg::ST_RESETTING;
      endcase
    end
  end

  always_ff @(posedge CLOCK_I) begin
    if (RESET_I) begin
      state_q <= laser_seq_pkg::ST_RESETTING;
      cnt_q <= '0;
    end else if (CE_I) begin
      state_q <= state_d;
      // held at zero under module reset so resetting always lasts in full
      cnt_q <= (state_d != state_q || mod_rst_s) ? '0 :
               cnt_q + laser_seq_pkg::CNT_W'(1);
    end
  end

  // control register; a module reset returns it to defaults
  always_comb begin
    ctl_d = ctl_q;
    if (mod_rst_s) begin
      ctl_d = laser_seq_pkg::CTL_RESET_VAL;
    end else if (ctl_wr) begin
      ctl_d = w_data_q[2:0];
    end
  end

  always_ff @(posedge CLOCK_I) begin
    if (RESET_I) begin
      ctl_q <= laser_seq_pkg::CTL_RESET_VAL;
    end else if (CE_I) begin
      ctl_q <= ctl_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // supply enables; laser and cooler registered from the next state, controller supply tied on

  always_ff @(posedge CLOCK_I) begin
    if (RESET_I) begin
      laser_q <= 1'b0;
      cooler_q <= 1'b0;
    end else if (CE_I) begin
      laser_q <= (state_d == laser_seq_pkg::ST_READY) &&
                 ctl_d[laser_seq_pkg::CTL_LASER_REQ];
      cooler_q <= (state_d == laser_seq_pkg::ST_READY) &&
                  ctl_d[laser_seq_pkg::CTL_COOLER_REQ];
    end
  end

  assign LASER_EN_O = laser_q;
  assign COOLER_EN_O = cooler_q;
  assign MCU_POWER_EN_O = 1'b1;
  assign MODULE_PRESENT_N_O = 1'b0;

  ////////////////////////////////////////////////////////////////////////
  // read path and power class report

  logic [3:0] pclass;

  // class 1 in low power, clamp to 1..10
  assign pclass = (state_q != laser_seq_pkg::ST_READY) ?
    laser_seq_pkg::PCLASS_LOW_POWER :
    (POWER_CLASS < laser_seq_pkg::PCLASS_MIN) ? laser_seq_pkg::PCLASS_MIN :
    (POWER_CLASS > laser_seq_pkg::PCLASS_MAX) ? laser_seq_pkg::PCLASS_MAX :
    POWER_CLASS;

  always_ff @(posedge CLOCK_I) begin
    if (RESET_I) begin
      rvalid_q <= 1'b0;
      rresp_q <= laser_seq_pkg::RESP_OKAY;
      rdata_q <= 32'h0;
    end else if (CE_I) begin
      if (S_AXI_ARVALID && S_AXI_ARREADY) begin
        rvalid_q <= 1'b1;
        rresp_q <= mapped(S_AXI_ARADDR) ? laser_seq_pkg::RESP_OKAY :
                   laser_seq_pkg::RESP_SLVERR;
        rdata_q <= 32'h0;
        unique case (S_AXI_ARADDR)
          laser_seq_pkg::OFS_CONTROL: rdata_q[2:0] <= ctl_q;
          laser_seq_pkg::OFS_STATUS: begin
            rdata_q[laser_seq_pkg::STS_STATE_LSB +: 3] <= state_q;
            rdata_q[laser_seq_pkg::STS_LASER] <= laser_q;
            rdata_q[laser_seq_pkg::STS_COOLER] <= cooler_q;
            rdata_q[laser_seq_pkg::STS_LP_REQ] <= lp_s;
          end
          laser_seq_pkg::OFS_POWER_CLASS: rdata_q[3:0] <= pclass;
          default: rdata_q <= 32'h0;
        endcase
      end else if (S_AXI_RREADY) begin
        rvalid_q <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // assertions

  default clocking cb @(posedge CLOCK_I); endclocking
  default disable iff (RESET_I);

  sequence s_step;
    CE_I && !mod_rst_s;
  endsequence

  sequence s_init_idle;
    state_q inside {laser_seq_pkg::ST_RESETTING, laser_seq_pkg::ST_RESET,
                    laser_seq_pkg::ST_MGMT_INIT};
  endsequence

  property p_off_early;
    s_init_idle |-> !LASER_EN_O && !COOLER_EN_O;
  endproperty
  a_off_early: assert property (p_off_early)
    else $error("laser or cooler on before low power");

  property p_resetting_done;
    state_q == laser_seq_pkg::ST_RESETTING ##0 s_step ##0 cnt_done
      |=> state_q == laser_seq_pkg::ST_RESET;
  endproperty
  a_resetting_done: assert property (p_resetting_done)
    else $error("resetting did not move to reset");

  property p_reset_wait;
    state_q == laser_seq_pkg::ST_RESET ##0 s_step
      |=> (state_q == laser_seq_pkg::ST_MGMT_INIT) ==
          !$past(ctl_q[laser_seq_pkg::CTL_RESET_FLAG]);
  endproperty
  a_reset_wait: assert property (p_reset_wait)
    else $error("reset state left against the flag");

  property p_init_to_lp;
    state_q == laser_seq_pkg::ST_MGMT_INIT ##0 s_step ##0 cnt_done
      |=> state_q == laser_seq_pkg::ST_LOW_POWER;
  endproperty
  a_init_to_lp: assert property (p_init_to_lp)
    else $error("init did not end in low power");

  property p_lp_dark;
    state_q == laser_seq_pkg::ST_LOW_POWER |-> !LASER_EN_O;
  endproperty
  a_lp_dark: assert property (p_lp_dark)
    else $error("laser on in low power");

  property p_laser_gate;
    $rose(LASER_EN_O) |-> state_q == laser_seq_pkg::ST_READY &&
      ctl_q[laser_seq_pkg::CTL_LASER_REQ];
  endproperty
  a_laser_gate: assert property (p_laser_gate)
    else $error("laser on without ready and request");

  property p_class_range;
    S_AXI_RVALID && $past(S_AXI_ARADDR) == laser_seq_pkg::OFS_POWER_CLASS &&
      $rose(S_AXI_RVALID) |-> S_AXI_RDATA[3:0] inside {[1:10]};
  endproperty
  a_class_range: assert property (p_class_range)
    else $error("power class out of range");

  property p_lp_hold;
    state_q == laser_seq_pkg::ST_READY ##0 s_step ##0 lp_s &&
      !ctl_q[laser_seq_pkg::CTL_RESET_FLAG]
      |=> state_q == laser_seq_pkg::ST_LOW_POWER && !LASER_EN_O;
  endproperty
  a_lp_hold: assert property (p_lp_hold)
    else $error("low power request not honoured");

  property p_mod_reset;
    CE_I && mod_rst_s |=> state_q == laser_seq_pkg::ST_RESETTING &&
      !LASER_EN_O ##1 (!CE_I || state_q != laser_seq_pkg::ST_READY);
  endproperty
  a_mod_reset: assert property (p_mod_reset)
    else $error("module reset did not restart the sequence");

endmodule

`default_nettype wire

/* File: testbench/host_pin_model.sv */
// host_pin_model: host controller side of the module control pins.
// assumes the bench sets the wanted levels; pins move after an edge.
`default_nettype none

module host_pin_model (
  input wire logic clock_i, // system clock
  input wire logic hold_reset_i, // keep the module in reset
  input wire logic low_power_i, // ask for low power mode
  input wire logic select_i, // select the module
  output logic module_select_n_o, // select pin, active low
  output logic module_reset_n_o, // reset pin, active low
  output logic low_power_request_o // low power pin
);
  timeunit 1ns;
  timeprecision 100ps;

  always @(posedge clock_i) begin
    module_reset_n_o <= !hold_reset_i;
  end

  always @(posedge clock_i) begin
    low_power_request_o <= low_power_i;
  end

  always @(posedge clock_i) begin
    module_select_n_o <= !select_i;
  end
endmodule

`default_nettype wire

/* File: testbench/laser_module_state_sequencer_bench.sv */
// laser_module_state_sequencer_bench: self-checking bench driving the
// register bus and, through the host model, the module control pins.
// assumes the design package and host model are compiled first.
`default_nettype none

module laser_module_state_sequencer_bench;
  timeunit 1ns;
  timeprecision 100ps;

  localparam logic [3:0] PCLASS = 4'h9;
  localparam logic [3:0] A_CTL = laser_seq_pkg::OFS_CONTROL;
  localparam logic [3:0] A_STS = laser_seq_pkg::OFS_STATUS;
  localparam logic [3:0] A_PCL = laser_seq_pkg::OFS_POWER_CLASS;
  localparam logic [3:0] A_BAD = 4'hC;
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic sel = 1'b1;
  logic hold_rst = 1'b1;
  logic lp = 1'b1;
  logic ce = 1'b1;
  wire logic sel_n, rst_n, lp_pin;
  logic present_n, mcu_en, laser_en, cooler_en;
  logic [3:0] awaddr = 4'h0;
  logic [3:0] araddr = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, r;
  logic [31:0] rdata, d;
  int compares = 0;
  int miscompares = 0;

  initial begin
    forever #2.5 clock = ~clock;
  end

  host_pin_model host (
    .clock_i(clock), .hold_reset_i(hold_rst), .low_power_i(lp),
    .select_i(sel), .module_select_n_o(sel_n),
    .module_reset_n_o(rst_n), .low_power_request_o(lp_pin)
  );

  laser_module_state_sequencer #(.POWER_CLASS(PCLASS)) uut (
    .CLOCK_I(clock), .RESET_I(reset), .CE_I(ce),
    .MODULE_SELECT_N_I(sel_n), .MODULE_RESET_N_I(rst_n),
    .LOW_POWER_REQUEST_I(lp_pin), .MODULE_PRESENT_N_O(present_n),
    .MCU_POWER_EN_O(mcu_en), .LASER_EN_O(laser_en),
    .COOLER_EN_O(cooler_en), .S_AXI_AWADDR(awaddr),
    .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
    .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wvalid),
    .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid),
    .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr),
    .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
    .S_AXI_RREADY(rready)
  );

  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // each channel is released at the edge where its ready was seen
  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    bit aw_ok = 1'b0;
    bit w_ok = 1'b0;
    @(posedge clock);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge clock);
      if (!aw_ok && awready === 1'b1) begin
        aw_ok = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w_ok && wready === 1'b1) begin
        w_ok = 1'b1;
        wvalid <= 1'b0;
      end
    end
    while (bvalid !== 1'b1) begin
      @(posedge clock);
    end
    r = bresp;
    bready <= 1'b0;
  endtask

  // only the watchdog ends a wait that never sees its ready or valid
  task automatic rd(input logic [3:0] a);
    @(posedge clock);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clock);
    end while (arready !== 1'b1);
    arvalid <= 1'b0;
    do begin
      @(posedge clock);
    end while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask

  task automatic wait_state(input laser_seq_pkg::mod_state_e s);
    for (int i = 0; i < 150; i++) begin
      rd(A_STS);
      if (d[2:0] === s) break;
    end
    chk({29'h0, d[2:0]}, {29'h0, s});
  endtask

  task automatic lasers(input logic [1:0] exp);
    chk({30'h0, laser_en, cooler_en}, {30'h0, exp});
  endtask

  ////////////////////////////////////////////////////////////////////////
  task automatic t_defaults();
    rd(A_CTL);
    chk(d, 32'h1);
    rd(A_STS);
    chk(d, 32'h40);
    rd(A_PCL);
    chk(d, {28'h0, laser_seq_pkg::PCLASS_LOW_POWER});
    lasers(2'b00);
    chk({30'h0, present_n, mcu_en}, 32'h1);
  endtask

  task automatic t_bringup();
    hold_rst <= 1'b0;
    wait_state(laser_seq_pkg::ST_RESET);
    repeat (20) @(posedge clock);
    rd(A_STS);
    chk({29'h0, d[2:0]}, 32'h1);
    wr(A_CTL, 32'h0);
    wait_state(laser_seq_pkg::ST_MGMT_INIT);
    wait_state(laser_seq_pkg::ST_LOW_POWER);
    lasers(2'b00);
    chk({31'h0, mcu_en}, 32'h1);
  endtask

  task automatic t_low_power_hold();
    wr(A_CTL, 32'h6);
    repeat (30) @(posedge clock);
    rd(A_STS);
    chk(d, 32'h43);
    lasers(2'b00);
  endtask

  // cooler alone first, then the laser on its own request
  task automatic t_ready();
    wr(A_CTL, 32'h4);
    lp <= 1'b0;
    wait_state(laser_seq_pkg::ST_READY);
    lasers(2'b01);
    wr(A_CTL, 32'h6);
    repeat (2) @(posedge clock);
    lasers(2'b11);
    rd(A_PCL);
    chk(d, {28'h0, PCLASS});
    lp <= 1'b1;
    wait_state(laser_seq_pkg::ST_LOW_POWER);
    lasers(2'b00);
    rd(A_PCL);
    chk(d, 32'h1);
    lp <= 1'b0;
    wait_state(laser_seq_pkg::ST_READY);
  endtask

  // a low clock enable freezes the block, pin synchronisers included
  task automatic t_freeze();
    ce <= 1'b0;
    lp <= 1'b1;
    repeat (10) @(posedge clock);
    lasers(2'b11);
    chk({31'h0, arready}, 32'h0);
    ce <= 1'b1;
    wait_state(laser_seq_pkg::ST_LOW_POWER);
    lasers(2'b00);
    lp <= 1'b0;
    wait_state(laser_seq_pkg::ST_READY);
  endtask

  task automatic t_deselect();
    sel <= 1'b0;
    repeat (5) @(posedge clock);
    wr(A_CTL, 32'h0);
    repeat (5) @(posedge clock);
    lasers(2'b11);
    sel <= 1'b1;
  endtask

  task automatic t_bus_errors();
    rd(A_BAD);
    chk({r, d[29:0]}, {laser_seq_pkg::RESP_SLVERR, 30'h0});
    wr(A_BAD, 32'h0);
    chk({30'h0, r}, {30'h0, laser_seq_pkg::RESP_SLVERR});
    wr(A_PCL, 32'h3);
    chk({30'h0, r}, {30'h0, laser_seq_pkg::RESP_OKAY});
    rd(A_PCL);
    chk(d, {28'h0, PCLASS});
  endtask

  task automatic t_module_reset();
    hold_rst <= 1'b1;
    wait_state(laser_seq_pkg::ST_RESETTING);
    lasers(2'b00);
    rd(A_CTL);
    chk(d, 32'h1);
    hold_rst <= 1'b0;
    wait_state(laser_seq_pkg::ST_RESET);
  endtask

  ////////////////////////////////////////////////////////////////////////
  task automatic summarize();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // the full run takes a few hundred cycles
  initial begin
    repeat (30000) @(posedge clock);
    miscompares++;
    summarize();
  end

  initial begin
    repeat (5) @(posedge clock);
    reset <= 1'b0;
    t_defaults();
    t_bringup();
    t_low_power_hold();
    t_ready();
    t_freeze();
    t_deselect();
    t_bus_errors();
    t_module_reset();
    summarize();
  end
endmodule

`default_nettype wire
